// file: inc/sfc_pkg.sv
// Contract
// - opcode 06 sets the write latch; host sends it before any modifying command.
// - opcode 04 clears the write latch, so later modifying commands are refused.
// - opcode 05 streams the status byte while chip select stays low.
// - opcode 01 plus one byte writes status; the cycle starts at deselect.
// - opcode 0b reads with a three-byte address and dummy clocks first.
// - opcode 3b takes the address on one line and returns data on two.
// - opcode bb takes address and mode on two lines and returns data there.
// - opcode eb carries address, mode byte and data on four lines.
// - toggling mode nibbles enter enhance mode; later quad reads skip the opcode.
// - opcode 20 with an address wipes the addressed sector.
// - opcode d8 with an address wipes the addressed block.
// - opcode 60 or c7 wipes the whole array, with no address.
// - opcode 38 programs a page with address and data on four lines.
// - opcode ab leaves power-down; after three dummy bytes the signature follows.
// - opcodes 90, ef, df read maker and part codes on one, two, four lines.
// - address 00 gives the maker code first, 01 the part code; then alternate.
// - as delivered every array byte reads ff.
// - as delivered the status register reads 00.
package sfc_pkg;
	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OPC_LATCH_SET = 8'h06;
	localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
	localparam logic [7:0] OPC_STAT_RD = 8'h05;
	localparam logic [7:0] OPC_STAT_WR = 8'h01;
	localparam logic [7:0] OPC_FAST_RD = 8'h0b;
	localparam logic [7:0] OPC_DUAL_OUT_RD = 8'h3b;
	localparam logic [7:0] OPC_DUAL_IO_RD = 8'hbb;
	localparam logic [7:0] OPC_QUAD_IO_RD = 8'heb;
	localparam logic [7:0] OPC_SECTOR_WIPE = 8'h20;
	localparam logic [7:0] OPC_BLOCK_WIPE = 8'hd8;
	localparam logic [7:0] OPC_CHIP_WIPE_A = 8'h60;
	localparam logic [7:0] OPC_CHIP_WIPE_B = 8'hc7;
	localparam logic [7:0] OPC_QUAD_PROG = 8'h38;
	localparam logic [7:0] OPC_SIG_RD = 8'hab;
	localparam logic [7:0] OPC_ID_RD_1 = 8'h90;
	localparam logic [7:0] OPC_ID_RD_2 = 8'hef;
	localparam logic [7:0] OPC_ID_RD_4 = 8'hdf;
	// ----------------------------------------
	// framing and layout
	// ----------------------------------------
	localparam int OPC_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam logic [4:0] DUMMY_FAST = 5'h08;
	localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
	localparam logic [4:0] DUMMY_QUAD_IO = 5'h06;
	localparam logic [4:0] DUMMY_ID_2 = 5'h04;
	localparam logic [4:0] DUMMY_ID_4 = 5'h06;
	localparam logic [4:0] SECTOR_SHIFT = 5'h0c;
	localparam logic [4:0] BLOCK_SHIFT = 5'h10;
	localparam logic [4:0] CHIP_SHIFT = 5'h18;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam longint CLK_PERIOD_NS = 4;
	localparam longint STAT_WR_MAX_MS = 100;
	localparam longint SECTOR_WIPE_MAX_MS = 300;
	localparam longint BLOCK_WIPE_MAX_S_X10 = 22;
	localparam longint CHIP_WIPE_MAX_S = 15;
	localparam longint PAGE_PROG_MAX_MS = 3;
	localparam longint STAT_WR_CYC = STAT_WR_MAX_MS * 1000000 / CLK_PERIOD_NS;
	localparam longint SECTOR_WIPE_CYC = SECTOR_WIPE_MAX_MS * 1000000 / CLK_PERIOD_NS;
	localparam longint BLOCK_WIPE_CYC = BLOCK_WIPE_MAX_S_X10 * 100000000 / CLK_PERIOD_NS;
	localparam longint CHIP_WIPE_CYC = CHIP_WIPE_MAX_S * 1000000000 / CLK_PERIOD_NS;
	localparam longint PAGE_PROG_CYC = PAGE_PROG_MAX_MS * 1000000 / CLK_PERIOD_NS;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000, OP_LSET = 4'b0001, OP_LCLR = 4'b0010, OP_SRD = 4'b0011,
		OP_SWR = 4'b0100, OP_RD = 4'b0101, OP_QRD = 4'b0110, OP_SWIPE = 4'b0111,
		OP_BWIPE = 4'b1000, OP_CWIPE = 4'b1001, OP_QPROG = 4'b1010, OP_SIG = 4'b1011,
		OP_ID = 4'b1100
	} sfc_op_t;
	typedef enum logic [2:0] {
		PH_OPC = 3'b000, PH_ADDR = 3'b001, PH_DUMMY = 3'b010,
		PH_OUT = 3'b011, PH_IN = 3'b100, PH_IDLE = 3'b101
	} sfc_phase_t;
	typedef struct packed {
		sfc_op_t op;
		logic [2:0] alanes;
		logic [2:0] dlanes;
		logic [4:0] dummy;
	} sfc_cmd_t;
	localparam sfc_cmd_t CMD_NONE = '{OP_NONE, 3'h1, 3'h1, 5'h00};
	localparam sfc_cmd_t CMD_QUAD_RD = '{OP_QRD, 3'h4, 3'h4, DUMMY_QUAD_IO};
endpackage : sfc_pkg

// file: src/sfc_pin_sync.sv
`timescale 1ns/1ns
module sfc_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : sfc_pin_sync

// file: src/sfc_busy_timer.sv
`timescale 1ns/1ns
module sfc_busy_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// start with cycle count
	input wire logic start,
	input wire logic [31:0] load,
	// cycle running
	output logic busy
);
	logic [31:0] count_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= 32'h0;
			busy <= 1'b0;
		end
		else if (start)
		begin
			count_reg <= load;
			busy <= 1'b1;
		end
		else if (count_reg > 32'h1)
			count_reg <= count_reg - 32'h1;
		else
		begin
			count_reg <= 32'h0;
			busy <= 1'b0;
		end
	end
endmodule : sfc_busy_timer

// file: src/sfc_core.sv
`timescale 1ns/1ns
module sfc_core #(
	parameter int MEM_AW = 8,
	parameter logic [7:0] SIGNATURE = 8'h5a, // arbitrary value
	parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] PART_ID = 8'h42, // arbitrary value
	parameter int unsigned STAT_WR_CYCLES = 32'(sfc_pkg::STAT_WR_CYC),
	parameter int unsigned SECTOR_WIPE_CYCLES = 32'(sfc_pkg::SECTOR_WIPE_CYC),
	parameter int unsigned BLOCK_WIPE_CYCLES = 32'(sfc_pkg::BLOCK_WIPE_CYC),
	parameter int unsigned CHIP_WIPE_CYCLES = 32'(sfc_pkg::CHIP_WIPE_CYC),
	parameter int unsigned PAGE_PROG_CYCLES = 32'(sfc_pkg::PAGE_PROG_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] data_line_in,
	// data line drive
	output logic [3:0] data_line_out,
	output logic [3:0] data_line_oe
);
	if (MEM_AW < 4 || MEM_AW > 24)
	begin : g_bad_aw
		$error("MEM_AW must lie in 4..24");
	end

	localparam logic [23:0] AMASK = 24'((1 << MEM_AW) - 1);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic sfc_pkg::sfc_cmd_t cmd_decode(input logic [7:0] opc);
		case (opc)
			sfc_pkg::OPC_LATCH_SET: return '{sfc_pkg::OP_LSET, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_LATCH_CLR: return '{sfc_pkg::OP_LCLR, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_STAT_RD: return '{sfc_pkg::OP_SRD, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_STAT_WR: return '{sfc_pkg::OP_SWR, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_FAST_RD: return '{sfc_pkg::OP_RD, 3'h1, 3'h1, sfc_pkg::DUMMY_FAST};
			sfc_pkg::OPC_DUAL_OUT_RD: return '{sfc_pkg::OP_RD, 3'h1, 3'h2, sfc_pkg::DUMMY_FAST};
			sfc_pkg::OPC_DUAL_IO_RD: return '{sfc_pkg::OP_RD, 3'h2, 3'h2, sfc_pkg::DUMMY_DUAL_IO};
			sfc_pkg::OPC_QUAD_IO_RD: return sfc_pkg::CMD_QUAD_RD;
			sfc_pkg::OPC_SECTOR_WIPE: return '{sfc_pkg::OP_SWIPE, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_BLOCK_WIPE: return '{sfc_pkg::OP_BWIPE, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_CHIP_WIPE_A: return '{sfc_pkg::OP_CWIPE, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_CHIP_WIPE_B: return '{sfc_pkg::OP_CWIPE, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_QUAD_PROG: return '{sfc_pkg::OP_QPROG, 3'h4, 3'h4, 5'h00};
			sfc_pkg::OPC_SIG_RD: return '{sfc_pkg::OP_SIG, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_ID_RD_1: return '{sfc_pkg::OP_ID, 3'h1, 3'h1, 5'h00};
			sfc_pkg::OPC_ID_RD_2: return '{sfc_pkg::OP_ID, 3'h2, 3'h2, sfc_pkg::DUMMY_ID_2};
			sfc_pkg::OPC_ID_RD_4: return '{sfc_pkg::OP_ID, 3'h4, 3'h4, sfc_pkg::DUMMY_ID_4};
			default: return sfc_pkg::CMD_NONE;
		endcase
	endfunction : cmd_decode

	function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] n, input logic [3:0] d);
		case (n)
			3'h1: return {v[22:0], d[0]};
			3'h2: return {v[21:0], d[1:0]};
			default: return {v[19:0], d};
		endcase
	endfunction : shift_in

	function automatic sfc_pkg::sfc_phase_t data_phase(input sfc_pkg::sfc_op_t op);
		case (op)
			sfc_pkg::OP_SRD, sfc_pkg::OP_RD, sfc_pkg::OP_QRD, sfc_pkg::OP_SIG, sfc_pkg::OP_ID:
				return sfc_pkg::PH_OUT;
			sfc_pkg::OP_SWR, sfc_pkg::OP_QPROG:
				return sfc_pkg::PH_IN;
			default:
				return sfc_pkg::PH_IDLE;
		endcase
	endfunction : data_phase

	function automatic logic needs_addr(input sfc_pkg::sfc_op_t op);
		return op inside {sfc_pkg::OP_RD, sfc_pkg::OP_QRD, sfc_pkg::OP_SWIPE, sfc_pkg::OP_BWIPE,
			sfc_pkg::OP_QPROG, sfc_pkg::OP_SIG, sfc_pkg::OP_ID};
	endfunction : needs_addr

	// ----------------------------------------
	// pin sampling and edges
	// ----------------------------------------
	logic [5:0] pins_s;
	logic cs_s, sclk_s, sclk_d_reg, cs_d_reg;
	logic [3:0] din;
	logic rise, fall, cs_fall, cs_rise;

	// the link clock is only sampled, so every pin shares one two-stage delay
	sfc_pin_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({cs_n, sclk, data_line_in}),
		.q(pins_s)
	);
	assign cs_s = pins_s[5];
	assign sclk_s = pins_s[4];
	assign din = pins_s[3:0];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
		end
		else
		begin
			sclk_d_reg <= sclk_s;
			cs_d_reg <= cs_s;
		end
	end
	assign rise = sclk_s & ~sclk_d_reg & ~cs_s;
	assign fall = ~sclk_s & sclk_d_reg & ~cs_s;
	assign cs_fall = ~cs_s & cs_d_reg;
	assign cs_rise = cs_s & ~cs_d_reg;

	// ----------------------------------------
	// command sequencing
	// ----------------------------------------
	sfc_pkg::sfc_phase_t phase_reg;
	sfc_pkg::sfc_cmd_t cmd_reg, dec;
	logic [4:0] cnt_reg;
	logic [23:0] sh_reg, sh_next;
	logic [3:0] mode_hi_reg;
	logic enh_reg, wip, wel_reg;

	assign sh_next = shift_in(sh_reg, (phase_reg == sfc_pkg::PH_ADDR) ? cmd_reg.alanes : 3'h1, din);
	assign dec = cmd_decode(sh_next[7:0]);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_reg <= sfc_pkg::PH_IDLE;
			cmd_reg <= sfc_pkg::CMD_NONE;
			cnt_reg <= 5'h0;
			sh_reg <= 24'h0;
			mode_hi_reg <= 4'h0;
			enh_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			phase_reg <= enh_reg ? sfc_pkg::PH_ADDR : sfc_pkg::PH_OPC;
			cmd_reg <= enh_reg ? sfc_pkg::CMD_QUAD_RD : sfc_pkg::CMD_NONE;
			cnt_reg <= enh_reg ? 5'(sfc_pkg::ADDR_BITS / 4) : 5'(sfc_pkg::OPC_BITS);
		end
		else if (rise)
		begin
			cnt_reg <= cnt_reg - 5'h1;
			case (phase_reg)
				sfc_pkg::PH_OPC:
				begin
					sh_reg <= sh_next;
					if (cnt_reg == 5'h1)
					begin
						if (wip && dec.op != sfc_pkg::OP_SRD)
						begin
							cmd_reg <= sfc_pkg::CMD_NONE;
							phase_reg <= sfc_pkg::PH_IDLE;
						end
						else
						begin
							cmd_reg <= dec;
							phase_reg <= needs_addr(dec.op) ? sfc_pkg::PH_ADDR : data_phase(dec.op);
							cnt_reg <= 5'(sfc_pkg::ADDR_BITS / 32'(dec.alanes));
						end
					end
				end
				sfc_pkg::PH_ADDR:
				begin
					sh_reg <= sh_next;
					if (cnt_reg == 5'h1)
					begin
						phase_reg <= (cmd_reg.dummy != 5'h0) ? sfc_pkg::PH_DUMMY : data_phase(cmd_reg.op);
						cnt_reg <= cmd_reg.dummy;
					end
				end
				sfc_pkg::PH_DUMMY:
				begin
					if (cmd_reg.op == sfc_pkg::OP_QRD && cnt_reg == sfc_pkg::DUMMY_QUAD_IO)
						mode_hi_reg <= din;
					if (cmd_reg.op == sfc_pkg::OP_QRD && cnt_reg == sfc_pkg::DUMMY_QUAD_IO - 5'h1)
						enh_reg <= (mode_hi_reg == ~din);
					if (cnt_reg == 5'h1)
						phase_reg <= data_phase(cmd_reg.op);
				end
				default:
					cnt_reg <= cnt_reg;
			endcase
		end
	end

	// ----------------------------------------
	// address and data in
	// ----------------------------------------
	logic [23:0] addr_reg;
	logic [7:0] in_sh_reg, in_byte, fetch_byte, out_sh_reg, out_v;
	logic [3:0] in_cnt_reg, out_left_reg;
	logic in_done, fetch, addr_done;
	logic [7:0] wr_byte_reg;
	logic wr_got_reg, prog_any_reg;

	assign addr_done = rise && phase_reg == sfc_pkg::PH_ADDR && cnt_reg == 5'h1;
	assign in_byte = (cmd_reg.dlanes == 3'h4) ? {in_sh_reg[3:0], din} :
		((cmd_reg.dlanes == 3'h2) ? {in_sh_reg[5:0], din[1:0]} : {in_sh_reg[6:0], din[0]});
	assign in_done = rise && phase_reg == sfc_pkg::PH_IN && (in_cnt_reg + 4'(cmd_reg.dlanes)) == 4'h8;
	assign fetch = fall && phase_reg == sfc_pkg::PH_OUT && out_left_reg == 4'h0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_reg <= 24'h0;
		else if (addr_done)
			addr_reg <= sh_next;
		else if (fetch && cmd_reg.op == sfc_pkg::OP_ID)
			addr_reg <= {addr_reg[23:1], ~addr_reg[0]};
		else if (fetch && cmd_reg.op inside {sfc_pkg::OP_RD, sfc_pkg::OP_QRD})
			addr_reg <= addr_reg + 24'h1;
		// programming wraps inside the page
		else if (in_done && cmd_reg.op == sfc_pkg::OP_QPROG)
			addr_reg <= {addr_reg[23:8], addr_reg[7:0] + 8'h1};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			in_sh_reg <= 8'h0;
			in_cnt_reg <= 4'h0;
			wr_byte_reg <= 8'h0;
			wr_got_reg <= 1'b0;
			prog_any_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			in_cnt_reg <= 4'h0;
			wr_got_reg <= 1'b0;
			prog_any_reg <= 1'b0;
		end
		else if (rise && phase_reg == sfc_pkg::PH_IN)
		begin
			in_sh_reg <= in_byte;
			in_cnt_reg <= in_done ? 4'h0 : in_cnt_reg + 4'(cmd_reg.dlanes);
			if (in_done && cmd_reg.op == sfc_pkg::OP_SWR && !wr_got_reg)
			begin
				wr_byte_reg <= in_byte;
				wr_got_reg <= 1'b1;
			end
			if (in_done && cmd_reg.op == sfc_pkg::OP_QPROG && wel_reg)
				prog_any_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// array
	// ----------------------------------------
	logic [7:0] mem [2**MEM_AW];
	logic wipe_go;
	logic [4:0] wipe_shift;

	function automatic logic in_region(input int idx, input logic [23:0] a, input logic [4:0] sh);
		return ((24'(idx) ^ (a & AMASK)) >> sh) == 24'h0;
	endfunction : in_region

	for (genvar i = 0; i < 2**MEM_AW; i++)
	begin : g_mem
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				mem[i] <= sfc_pkg::ERASED_BYTE;
			else if (wipe_go && in_region(i, addr_reg, wipe_shift))
				mem[i] <= sfc_pkg::ERASED_BYTE;
			else if (in_done && cmd_reg.op == sfc_pkg::OP_QPROG && wel_reg && addr_reg[MEM_AW-1:0] == MEM_AW'(i))
				mem[i] <= mem[i] & in_byte;
		end
	end

	// ----------------------------------------
	// status and write cycles
	// ----------------------------------------
	logic [7:2] stat_hi_reg;
	logic tstart, ready_end;
	logic [31:0] tload;

	assign ready_end = cs_rise && phase_reg == sfc_pkg::PH_IDLE && wel_reg && !wip;

	always_comb
	begin
		tstart = 1'b0;
		tload = 32'h0;
		wipe_go = 1'b0;
		wipe_shift = sfc_pkg::CHIP_SHIFT;
		case (cmd_reg.op)
			sfc_pkg::OP_SWR:
			begin
				tstart = cs_rise && wr_got_reg && wel_reg && !wip;
				tload = STAT_WR_CYCLES;
			end
			sfc_pkg::OP_SWIPE:
			begin
				tstart = ready_end;
				tload = SECTOR_WIPE_CYCLES;
				wipe_shift = sfc_pkg::SECTOR_SHIFT;
			end
			sfc_pkg::OP_BWIPE:
			begin
				tstart = ready_end;
				tload = BLOCK_WIPE_CYCLES;
				wipe_shift = sfc_pkg::BLOCK_SHIFT;
			end
			sfc_pkg::OP_CWIPE:
			begin
				tstart = ready_end;
				tload = CHIP_WIPE_CYCLES;
			end
			sfc_pkg::OP_QPROG:
			begin
				tstart = cs_rise && prog_any_reg;
				tload = PAGE_PROG_CYCLES;
			end
			default:
				tstart = 1'b0;
		endcase
		wipe_go = tstart && cmd_reg.op inside {sfc_pkg::OP_SWIPE, sfc_pkg::OP_BWIPE, sfc_pkg::OP_CWIPE};
	end

	sfc_busy_timer u_timer (
		.clk(clk),
		.rst(rst),
		.start(tstart),
		.load(tload),
		.busy(wip)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stat_hi_reg <= sfc_pkg::STAT_RESET[7:2];
			wel_reg <= sfc_pkg::STAT_RESET[1];
		end
		else if (cs_rise && cmd_reg.op == sfc_pkg::OP_LSET && phase_reg == sfc_pkg::PH_IDLE)
			wel_reg <= 1'b1;
		else if (cs_rise && cmd_reg.op == sfc_pkg::OP_LCLR && phase_reg == sfc_pkg::PH_IDLE)
			wel_reg <= 1'b0;
		else if (tstart)
		begin
			if (cmd_reg.op == sfc_pkg::OP_SWR)
				stat_hi_reg <= wr_byte_reg[7:2];
			wel_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// data out, driven on falling clock
	// ----------------------------------------
	always_comb
	begin
		case (cmd_reg.op)
			sfc_pkg::OP_SRD: fetch_byte = {stat_hi_reg, wel_reg, wip};
			sfc_pkg::OP_SIG: fetch_byte = SIGNATURE;
			sfc_pkg::OP_ID: fetch_byte = addr_reg[0] ? PART_ID : MAKER_ID;
			default: fetch_byte = mem[addr_reg[MEM_AW-1:0]];
		endcase
	end
	assign out_v = (out_left_reg == 4'h0) ? fetch_byte : out_sh_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_sh_reg <= 8'h0;
			out_left_reg <= 4'h0;
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
		end
		else if (cs_s || phase_reg != sfc_pkg::PH_OUT)
		begin
			out_left_reg <= 4'h0;
			data_line_oe <= 4'h0;
		end
		else if (fall)
		begin
			out_sh_reg <= out_v << cmd_reg.dlanes;
			out_left_reg <= ((out_left_reg == 4'h0) ? 4'h8 : out_left_reg) - 4'(cmd_reg.dlanes);
			case (cmd_reg.dlanes)
				3'h1:
				begin
					data_line_out <= {2'b00, out_v[7], 1'b0};
					data_line_oe <= 4'b0010;
				end
				3'h2:
				begin
					data_line_out <= {2'b00, out_v[7:6]};
					data_line_oe <= 4'b0011;
				end
				default:
				begin
					data_line_out <= out_v[7:4];
					data_line_oe <= 4'b1111;
				end
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_end(sfc_pkg::sfc_op_t o);
		cs_rise && cmd_reg.op == o && phase_reg == sfc_pkg::PH_IDLE;
	endsequence
	sequence s_opc_last;
		rise && phase_reg == sfc_pkg::PH_OPC && cnt_reg == 5'h1;
	endsequence
	sequence s_fetch(sfc_pkg::sfc_op_t o);
		fetch && cmd_reg.op == o;
	endsequence

	AST_LATCH_SET: assert property (s_end(sfc_pkg::OP_LSET) |=> wel_reg ##1 wel_reg)
		else $error("write latch not set");
	AST_LATCH_CLR: assert property (s_end(sfc_pkg::OP_LCLR) |=> !wel_reg)
		else $error("write latch not cleared");
	AST_STAT_STREAM: assert property (s_fetch(sfc_pkg::OP_SRD)
		|=> data_line_oe == 4'b0010 && data_line_out[1] == $past(stat_hi_reg[7]))
		else $error("status not driven on line one");
	AST_STAT_WRITE: assert property (cs_rise && cmd_reg.op == sfc_pkg::OP_SWR && wr_got_reg && wel_reg && !wip
		|=> wip && !wel_reg && stat_hi_reg == $past(wr_byte_reg[7:2]))
		else $error("status write cycle not started");
	AST_DUAL_OE: assert property (fall && phase_reg == sfc_pkg::PH_OUT && cmd_reg.dlanes == 3'h2 |=> data_line_oe == 4'b0011)
		else $error("dual output lanes wrong");
	AST_QUAD_OE: assert property (fall && phase_reg == sfc_pkg::PH_OUT && cmd_reg.dlanes == 3'h4 |=> data_line_oe == 4'b1111)
		else $error("quad output lanes wrong");
	AST_ENHANCE: assert property (cs_fall && enh_reg |=> phase_reg == sfc_pkg::PH_ADDR && cmd_reg.op == sfc_pkg::OP_QRD)
		else $error("enhance mode did not skip opcode");
	AST_WIPE_REFUSED: assert property ((s_end(sfc_pkg::OP_SWIPE) and (!wel_reg && !wip)) |=> !wip)
		else $error("wipe ran without latch");
	AST_CHIP_WIPE: assert property ((s_end(sfc_pkg::OP_CWIPE) and (wel_reg && !wip))
		|=> wip && !wel_reg && mem[0] == 8'hff)
		else $error("chip wipe not started");
	AST_SIGNATURE: assert property (s_fetch(sfc_pkg::OP_SIG) |=> {data_line_out[1], out_sh_reg[7:1]} == SIGNATURE)
		else $error("signature bit wrong");
	AST_ID_ORDER: assert property ((s_fetch(sfc_pkg::OP_ID) and cmd_reg.dlanes == 3'h1)
		|=> {data_line_out[1], out_sh_reg[7:1]} == ($past(addr_reg[0]) ? PART_ID : MAKER_ID))
		else $error("identifier order wrong");
	AST_OPCODE: assert property ((s_opc_last and !wip) |=> cmd_reg == $past(dec))
		else $error("opcode not decoded");
	AST_BUSY_REFUSE: assert property ((s_opc_last and (wip && dec.op != sfc_pkg::OP_SRD))
		|=> phase_reg == sfc_pkg::PH_IDLE && cmd_reg.op == sfc_pkg::OP_NONE)
		else $error("command accepted while busy");
endmodule : sfc_core

// file: dv/sfc_host_model.sv
`timescale 1ns/1ns
module sfc_host_model #(
	parameter int HALF = 20,
	parameter int PWR_UP_CYC = 750
) (
	// clock
	input wire logic clk,
	// link to the device
	output logic cs_n,
	output logic sclk,
	output logic [3:0] line,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe
);
	logic si = 1'b0;
	logic flip = 1'b0;
	logic qmode = 1'b0;
	logic [3:0] qd = 4'h0;
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	// released lines toggle so a stale level never passes for data
	always_ff @(posedge clk) flip <= ~flip;
	assign line = (dev_oe & dev_out) | (~dev_oe & (qmode ? qd : {flip, ~flip, flip, si}));
	task automatic power_up();
		repeat (PWR_UP_CYC) @(posedge clk);
	endtask : power_up
	task automatic select();
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (HALF) @(posedge clk);
	endtask : select
	task automatic deselect();
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		qmode <= 1'b0;
		repeat (HALF) @(posedge clk);
	endtask : deselect
	// every lane actively driven for the whole clock
	task automatic lane_xfer(input logic [3:0] o, output logic [3:0] i);
		qmode <= 1'b1;
		qd <= o;
		repeat (HALF) @(posedge clk);
		i = line;
		sclk <= 1'b1;
		repeat (HALF) @(posedge clk);
		sclk <= 1'b0;
	endtask : lane_xfer
	// mode 0: data set while low, device output taken at the rising edge
	task automatic bit_xfer(input logic o, output logic i);
		si <= o;
		repeat (HALF) @(posedge clk);
		i = line[1];
		sclk <= 1'b1;
		repeat (HALF) @(posedge clk);
		sclk <= 1'b0;
	endtask : bit_xfer
	task automatic byte_xfer(input logic [7:0] o, output logic [7:0] i);
		for (int b = 7; b >= 0; b--)
			bit_xfer(o[b], i[b]);
	endtask : byte_xfer
endmodule : sfc_host_model

// file: dv/sfc_core_tb_top.sv
`timescale 1ns/1ns
module sfc_core_tb_top;
	localparam logic [7:0] SIG = 8'h5a; // arbitrary value
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
	localparam logic [7:0] PART = 8'h42; // arbitrary value
	typedef struct {logic [39:0] c; int nc; int nr; logic [15:0] e;} sfc_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n;
	logic sclk;
	logic [3:0] line;
	logic [3:0] dout;
	logic [3:0] doe;
	logic [15:0] r;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	sfc_row_t rows [9] = '{'{40'h0500000000, 1, 2, 16'h0000}, '{40'h0b00001000, 5, 2, 16'hffff},
		'{40'hab00000000, 4, 2, {SIG, SIG}}, '{40'h9000000000, 4, 2, {MAKER, PART}},
		'{40'h9000000100, 4, 2, {PART, MAKER}}, '{40'h0600000000, 1, 0, 16'h0000},
		'{40'h0500000000, 1, 2, 16'h0202}, '{40'h0400000000, 1, 0, 16'h0000},
		'{40'h0500000000, 1, 2, 16'h0000}};
	sfc_row_t mods [5] = '{'{40'h2000001000, 4, 0, 16'h0101}, '{40'hd800001000, 4, 0, 16'h0101},
		'{40'h6000000000, 1, 0, 16'h0101}, '{40'hc700000000, 1, 0, 16'h0101},
		'{40'h0100000000, 2, 0, 16'h0101}};
	// single-line bytes, then lane groups, then reads of w bits per clock
	typedef struct {logic [39:0] c; int nc; logic [63:0] ln; int n; int w; int nr; logic [15:0] e;} sfc_lrow_t;
	sfc_lrow_t lrows [10] = '{'{40'h0600000000, 1, 64'h0, 0, 1, 0, 16'h0000},
		'{40'h3800000000, 1, 64'h000010a500000000, 8, 4, 0, 16'h0000},
		'{40'h0b00001000, 5, 64'h0, 0, 1, 16, 16'ha5ff}, '{40'h3b00001000, 5, 64'h0, 0, 2, 8, 16'ha5ff},
		'{40'hbb00000000, 1, 64'h0000000001000000, 16, 2, 8, 16'ha5ff},
		'{40'heb00000000, 1, 64'h000010a500000000, 12, 4, 4, 16'ha5ff},
		'{40'h0000000000, 0, 64'h0000100000000000, 12, 4, 4, 16'ha5ff},
		'{40'h0500000000, 1, 64'h0, 0, 1, 16, 16'h0000},
		'{40'hef00000000, 1, 64'h0000000000010000, 16, 2, 8, {PART, MAKER}},
		'{40'hdf00000000, 1, 64'h0, 12, 4, 4, {MAKER, PART}}};
	initial forever #2 clk = ~clk;
	sfc_core #(.SIGNATURE(SIG), .MAKER_ID(MAKER), .PART_ID(PART), .STAT_WR_CYCLES(2000),
		.SECTOR_WIPE_CYCLES(2000), .BLOCK_WIPE_CYCLES(2000), .CHIP_WIPE_CYCLES(2000),
		.PAGE_PROG_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
		.data_line_in(line), .data_line_out(dout), .data_line_oe(doe));
	sfc_host_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk),
		.line(line), .dev_out(dout), .dev_oe(doe));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic run(input logic [39:0] c, input int nc, input int nr, output logic [15:0] q);
		logic [7:0] d;
		q = 16'h0000;
		host_u.select();
		for (int k = 0; k < nc; k++)
			host_u.byte_xfer(c[39-8*k -: 8], d);
		for (int k = 0; k < nr; k++)
		begin
			host_u.byte_xfer(8'h00, d);
			q[15-8*k -: 8] = d;
		end
		host_u.deselect();
	endtask : run
	task automatic lrun(input sfc_lrow_t t, output logic [15:0] q);
		logic [7:0] d;
		logic [3:0] i;
		q = 16'h0000;
		host_u.select();
		for (int k = 0; k < t.nc; k++)
			host_u.byte_xfer(t.c[39-8*k -: 8], d);
		for (int k = 0; k < t.n; k++)
			host_u.lane_xfer(t.ln[63-4*k -: 4], i);
		for (int k = 0; k < t.nr; k++)
		begin
			host_u.lane_xfer(4'h0, i);
			q = (q << t.w) | ((t.w == 1) ? 16'(i[1]) : ((t.w == 2) ? 16'(i[1:0]) : 16'(i)));
		end
		host_u.deselect();
	endtask : lrun
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	// hang guard, well above the expected run of about 71k cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		host_u.power_up();
		foreach (rows[k])
		begin
			run(rows[k].c, rows[k].nc, rows[k].nr, r);
			if (rows[k].nr > 0) chk("row readback", rows[k].e, r);
		end
		foreach (lrows[k])
		begin
			lrun(lrows[k], r);
			if (lrows[k].nr > 0) chk("lane readback", lrows[k].e, r);
		end
		run(40'h6000000000, 1, 0, r);
		run(40'h2000001000, 4, 0, r);
		run(40'h0500000000, 1, 2, r);
		chk("wipe without latch", 16'h0000, r);
		run(40'h0b00001000, 5, 2, r);
		chk("array kept without latch", 16'ha5ff, r);
		foreach (mods[k])
		begin
			run(40'h0600000000, 1, 0, r);
			run(mods[k].c, mods[k].nc, 0, r);
			run(40'h0500000000, 1, 2, r);
			chk("status while busy", mods[k].e, r);
			// refused while busy, so the latch must stay clear
			run(40'h0600000000, 1, 0, r);
			repeat (2000) @(posedge clk);
			run(40'h0500000000, 1, 2, r);
			chk("status after cycle", 16'h0000, r);
			run(40'h0b00001000, 5, 2, r);
			chk("array after cycle", 16'hffff, r);
		end
		run(40'h0600000000, 1, 0, r);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		run(40'h0500000000, 1, 2, r);
		chk("status after reset", 16'h0000, r);
		end_of_test();
	end
endmodule : sfc_core_tb_top
